// File: jfcc_pkg.sv
// Package for the test-port fuse check control block
package jfcc_pkg;

    // Device variant selects how the check current path is gated
    typedef enum logic [0:0] {
        JFCC_VAR_MASKROM = 1'b0,
        JFCC_VAR_OTP     = 1'b1
    } jfcc_variant_t;

    // Fuse check mode sequencer
    typedef enum logic [1:0] {
        JFCC_ST_ARMED   = 2'b00,
        JFCC_ST_ACTIVE  = 2'b01,
        JFCC_ST_LOCKED  = 2'b10
    } jfcc_state_t;

    // Edge events from the mode-select synchroniser
    typedef struct packed {
        logic level;
        logic fall;
        logic rise;
    } jfcc_edge_t;

    // Test port pin group towards the core logic
    typedef struct packed {
        logic tdo_out;
        logic tdo_oe_n;
        logic port_en;
    } jfcc_port_t;

    localparam int unsigned JFCC_SYNC_STAGES   = 2;
    localparam int unsigned JFCC_RISE_CNT_W    = 2;
    localparam logic [1:0]  JFCC_RISE_EXIT     = 2'h2;
    localparam logic [1:0]  JFCC_RISE_RST      = 2'h0;
    localparam logic        JFCC_TMS_IDLE      = 1'b1;

endpackage : jfcc_pkg

// File: jfcc_sync_edge.sv
// Synchroniser and edge detector for the mode-select pin
`timescale 1ns/1ps
module jfcc_sync_edge
    import jfcc_pkg::*;
#(
    parameter int unsigned STAGES = JFCC_SYNC_STAGES
)(
    input  wire logic       i_clk_sys,  // System clock
    input  wire logic       i_arst_n,   // Async reset, active low
    input  wire logic       i_pin,      // Raw pin level
    output jfcc_edge_t      o_edge      // Synced level and edges
);

    if (STAGES < 2)
    begin : g_bad_stages
        $error("jfcc_sync_edge: STAGES must be at least 2");
    end

    logic [STAGES-1:0] sync_ff;
    logic              last_ff;

    // Pin idles high through its pull-up
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            sync_ff <= {STAGES{JFCC_TMS_IDLE}};
        else
            sync_ff <= {sync_ff[STAGES-2:0], i_pin};
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            last_ff <= JFCC_TMS_IDLE;
        else
            last_ff <= sync_ff[STAGES-1];
    end

    always_comb
    begin
        o_edge.level = sync_ff[STAGES-1];
        o_edge.fall  = last_ff & ~sync_ff[STAGES-1];
        o_edge.rise  = ~last_ff & sync_ff[STAGES-1];
    end

endmodule : jfcc_sync_edge

// File: jfcc_top.sv
// Test-port fuse check mode control
`timescale 1ns/1ps
// Summary of operation
// RULE1 - First falling select edge after reset enters fuse check mode.
// RULE2 - Second rising select edge after reset leaves the mode.
// RULE3 - After leaving, further edges never re-enter until reset.
// RULE4 - Each power-on reset re-arms the mechanism.
// RULE5 - Mask-ROM parts enable current only when active and select low.
// RULE6 - OTP parts enable the check current for the whole active time.
// RULE7 - A blown fuse permanently blocks all test port access.
// RULE8 - After reset the shared data-out pin stays high impedance until test logic drives it.
// RULE9 - The controller should idle mode-select high.
// RULE10 - Select is synchronised; one fall and two rises count.
module jfcc_top
    import jfcc_pkg::*;
#(
    parameter jfcc_variant_t VARIANT = JFCC_VAR_MASKROM
)(
    input  wire logic   i_clk_sys,      // System clock, 100 MHz
    input  wire logic   i_arst_n,       // Power-on reset, active low
    input  wire logic   i_tms,          // Mode-select pin level
    input  wire logic   i_fuse_blown,   // Security fuse sensed blown
    input  wire logic   i_tdo_data,     // Data from test logic
    input  wire logic   i_tdo_drive,    // Test logic wants to drive
    output logic        o_fuse_chk_act, // Fuse check mode active
    output logic        o_fuse_chk_en,  // Check current path enable
    output logic        o_port_en,      // Test port access allowed
    output logic        o_tdo_out,      // Data-out pin value
    output logic        o_tdo_oe_n      // Data-out enable, low drives
);

    jfcc_edge_t                edge_s;
    jfcc_state_t               state_ff;
    jfcc_state_t               nxt_state;
    logic [JFCC_RISE_CNT_W-1:0] rise_cnt_ff;
    logic [JFCC_RISE_CNT_W-1:0] nxt_rise_cnt;
    logic                      chk_en_ff;
    logic                      nxt_chk_en;
    logic                      blown_ff;
    jfcc_port_t                port_ff;
    jfcc_port_t                nxt_port;

    jfcc_sync_edge #(
        .STAGES (JFCC_SYNC_STAGES)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_tms),
        .o_edge    (edge_s)      // see RULE10
    );

    // Rise count has reached the exit value
    function automatic logic jfcc_is_exit(
        input logic [JFCC_RISE_CNT_W-1:0] cnt
    );
        return (cnt == JFCC_RISE_EXIT);
    endfunction : jfcc_is_exit

    // Rising edges counted per reset epoch, saturating
    always_comb
    begin
        nxt_rise_cnt = rise_cnt_ff;
        if (edge_s.rise && rise_cnt_ff != JFCC_RISE_EXIT)
            nxt_rise_cnt = rise_cnt_ff + 2'h1; // see RULE10
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rise_cnt_ff <= JFCC_RISE_RST; // see RULE4
        else
            rise_cnt_ff <= nxt_rise_cnt;
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            JFCC_ST_ARMED:
            begin
                if (jfcc_is_exit(nxt_rise_cnt))
                    nxt_state = JFCC_ST_LOCKED;  // see RULE2
                else if (edge_s.fall)
                    nxt_state = JFCC_ST_ACTIVE;  // see RULE1
            end
            JFCC_ST_ACTIVE:
            begin
                if (jfcc_is_exit(nxt_rise_cnt))
                    nxt_state = JFCC_ST_LOCKED;  // see RULE2
            end
            JFCC_ST_LOCKED:
                nxt_state = JFCC_ST_LOCKED;      // see RULE3
            default:
                nxt_state = JFCC_ST_LOCKED;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            state_ff <= JFCC_ST_ARMED;           // see RULE4
        else
            state_ff <= nxt_state;
    end

    // Current path gating per variant
    always_comb
    begin
        nxt_chk_en = 1'b0;
        if (nxt_state == JFCC_ST_ACTIVE)
        begin
            if (VARIANT == JFCC_VAR_OTP)
                nxt_chk_en = 1'b1;               // see RULE6
            else
                nxt_chk_en = ~edge_s.level;      // see RULE5 see RULE9
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            chk_en_ff <= 1'b0;
        else
            chk_en_ff <= nxt_chk_en;
    end

    // Blown fuse latched; released only by reset
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            blown_ff <= 1'b0;
        else if (i_fuse_blown)
            blown_ff <= 1'b1;                    // see RULE7
    end

    always_comb
    begin
        nxt_port.port_en  = ~blown_ff & ~i_fuse_blown;       // see RULE7
        nxt_port.tdo_oe_n = ~(nxt_port.port_en & i_tdo_drive);
        nxt_port.tdo_out  = nxt_port.tdo_oe_n ? 1'b0 : i_tdo_data;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            port_ff.port_en  <= 1'b0;
            port_ff.tdo_oe_n <= 1'b1;            // see RULE8
            port_ff.tdo_out  <= 1'b0;
        end
        else
            port_ff <= nxt_port;
    end

    assign o_fuse_chk_act = (state_ff == JFCC_ST_ACTIVE);
    assign o_fuse_chk_en  = chk_en_ff;
    assign o_port_en      = port_ff.port_en;
    assign o_tdo_out      = port_ff.tdo_out;
    assign o_tdo_oe_n     = port_ff.tdo_oe_n;

endmodule : jfcc_top

// File: jfcc_sva.sv
// Assertions for the fuse check control block
`timescale 1ns/1ps
module jfcc_sva
    import jfcc_pkg::*;
#(
    parameter jfcc_variant_t VARIANT = JFCC_VAR_MASKROM
)(
    input wire logic i_clk_sys,      // Clock
    input wire logic i_arst_n,       // Reset
    input wire logic i_tms,          // Select
    input wire logic i_fuse_blown,   // Fuse
    input wire logic i_tdo_data,     // Data
    input wire logic i_tdo_drive,    // Drive
    input wire logic o_fuse_chk_act, // Mode
    input wire logic o_fuse_chk_en,  // Current
    input wire logic o_port_en,      // Access
    input wire logic o_tdo_out,      // Out
    input wire logic o_tdo_oe_n      // Enable
);
    logic done_ff;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            done_ff <= 1'b0;
        else if ($fell(o_fuse_chk_act))
            done_ff <= 1'b1;
    end
    chk_lock_out: assert property (done_ff |-> !o_fuse_chk_act)
        else $error("mode re-entered");
    chk_mask_idle: assert property (
        (VARIANT == JFCC_VAR_MASKROM && i_tms) [*5] |-> !o_fuse_chk_en)
        else $error("current while idle");
    chk_otp_hold: assert property (
        VARIANT == JFCC_VAR_OTP && o_fuse_chk_act && $past(o_fuse_chk_act)
        |-> o_fuse_chk_en) else $error("otp gap");
    chk_en_in_mode: assert property (o_fuse_chk_en |-> o_fuse_chk_act)
        else $error("current outside mode");
    chk_fuse_block: assert property (i_fuse_blown |=> !o_port_en
        && o_tdo_oe_n) else $error("blown port open");
    chk_fuse_sticky: assert property (
        $fell(o_port_en) |=> !o_port_en [*8]) else $error("port reopened");
    chk_hiz_idle: assert property (!i_tdo_drive |=> o_tdo_oe_n)
        else $error("pin driven");
    chk_drive_path: assert property (i_tdo_drive && !i_fuse_blown &&
        o_port_en |=> !o_tdo_oe_n && o_tdo_out == $past(i_tdo_data))
        else $error("drive lost");
endmodule : jfcc_sva
bind jfcc_top jfcc_sva #(.VARIANT(VARIANT)) i_sva (.*);

// File: jfcc_jtag_mdl.sv
// External test controller model driving mode-select
`timescale 1ns/1ps
module jfcc_jtag_mdl (
    input  wire logic i_clk_sys, // Clock
    input  wire logic i_low,     // Request low
    output logic      o_tms      // Select drive
);
    // Single driver; sync flops hold idle high until first edge
    always_ff @(posedge i_clk_sys)
    begin
        o_tms <= ~i_low; // Idles high
    end
endmodule : jfcc_jtag_mdl

// File: jfcc_tb_top.sv
// Self-checking bench for the fuse check control block
`timescale 1ns/1ps
module jfcc_tb_top;
    import jfcc_pkg::*;
    logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_fuse_blown = 1'b0;
    logic i_tdo_data = 1'b0, i_tdo_drive = 1'b0, tms_low = 1'b0, i_tms;
    logic [1:0] act, en, pen, tout, oen;
    logic act_m, lvl, dm, dd;
    int fail_count = 0, tests_run = 0, seed = 93, rises;
    always #5 i_clk_sys = ~i_clk_sys;
    jfcc_jtag_mdl i_ctl (.i_clk_sys, .i_low(tms_low), .o_tms(i_tms));
    jfcc_top #(.VARIANT(JFCC_VAR_MASKROM)) i_dut (.*,
        .o_fuse_chk_act(act[0]), .o_fuse_chk_en(en[0]), .o_port_en(pen[0]),
        .o_tdo_out(tout[0]), .o_tdo_oe_n(oen[0]));
    jfcc_top #(.VARIANT(JFCC_VAR_OTP)) i_otp (.*,
        .o_fuse_chk_act(act[1]), .o_fuse_chk_en(en[1]), .o_port_en(pen[1]),
        .o_tdo_out(tout[1]), .o_tdo_oe_n(oen[1]));
    task automatic chk(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %b got %b", nm, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic step(input logic lv);
        tms_low <= ~lv;
        if (lv && !lvl)
            rises++;
        if (!lv && lvl && rises < 2)
            act_m = 1'b1;
        if (rises == 2)
            act_m = 1'b0;
        lvl = lv;
        repeat (7) @(posedge i_clk_sys);
        #1;
        chk("act", act_m, act[0]);
        chk("act_otp", act_m, act[1]);
        chk("en", act_m & ~lv, en[0]);
        chk("en_otp", act_m, en[1]);
    endtask : step
    initial
    begin
        for (int e = 0; e < 2; e++)
        begin
            repeat (16) @(posedge i_clk_sys);
            i_arst_n <= 1'b1;
            rises = 0;
            act_m = 1'b0;
            lvl = 1'b1;
            repeat (2) @(posedge i_clk_sys);
            #1;
            chk("oe_n", 1'b1, oen[0]);
            for (int k = 0; k < 6; k++)
                step(k[0]);
            i_arst_n <= 1'b0;
        end
        i_arst_n <= 1'b1;
        repeat (20)
        begin
            @(posedge i_clk_sys);
            dm = 1'($random(seed));
            dd = 1'($random(seed));
            i_tdo_drive <= dm;
            i_tdo_data <= dd;
            @(posedge i_clk_sys);
            #1;
            chk("oe_n", ~dm, oen[0]);
            chk("out", dm & dd, tout[0]);
            chk("port_open", 1'b1, pen[0]);
        end
        @(posedge i_clk_sys);
        i_tdo_drive <= 1'b1;
        i_fuse_blown <= 1'b1;
        @(posedge i_clk_sys);
        i_fuse_blown <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk("port", 1'b0, pen[0]);
        chk("oe_n", 1'b1, oen[1]);
        test_done();
    end
endmodule : jfcc_tb_top
